/* logic/host_port.sv */
`timescale 1ns/100ps
`default_nettype none
module host_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic wd_clear,
  // command writes for this host
  input wire logic cmd_wr,
  input wire logic [ipp_pkg::PTR_W-1:0] cmd_pointer,
  input wire logic [ipp_pkg::PAGE_W-1:0] cmd_page,
  input wire logic en_set,
  input wire logic en_clr,
  // data port traffic
  input wire logic data_rd,
  input wire logic poke_try,
  // energy accumulators
  input wire logic [47:0] energy_value,
  input wire logic [47:0] energy_time,
  // cached state
  output logic [ipp_pkg::PTR_W-1:0] pointer,
  output logic [ipp_pkg::PAGE_W-1:0] page,
  output logic poke_en,
  output logic [1:0] fail,
  output logic poke_ok,
  output logic [15:0] readout_word
);
  import ipp_pkg::*;

  host_state_t st;
  host_state_t next_st;

  assign pointer = st.pointer;
  assign page = st.page;
  assign poke_en = st.poke_en;
  assign fail = st.fail;
  // pokes need the enable and a legal page
  assign poke_ok = st.poke_en && (st.page <= MAX_PAGE);

  // energy readout word sequence, zeros past the end
  always_comb begin
    case (st.idx)
      3'h0: readout_word = ENERGY_LEN;
      3'h1: readout_word = st.snap_e[15:0];
      3'h2: readout_word = st.snap_e[31:16];
      3'h3: readout_word = st.snap_e[47:32];
      3'h4: readout_word = st.snap_t[15:0];
      3'h5: readout_word = st.snap_t[31:16];
      3'h6: readout_word = st.snap_t[47:32];
      default: readout_word = 16'h0000;
    endcase
  end

  // next state
  always_comb begin
    next_st = st;
    if (cmd_wr) begin
      next_st.pointer = cmd_pointer;
      next_st.page = cmd_page;
      next_st.idx = 3'h0;
      // snapshot so the six words belong to one instant
      if (cmd_pointer == ENERGY_PTR) begin
        next_st.snap_e = energy_value;
        next_st.snap_t = energy_time;
      end
    end else if (data_rd && st.pointer == ENERGY_PTR && st.idx != IDX_END) begin
      next_st.idx = st.idx + 3'h1;
    end
    if (en_set) begin
      next_st.poke_en = 1'b1;
    end else if (en_clr) begin
      next_st.poke_en = 1'b0;
    end
    if (poke_try) begin
      // bit0: not enabled, bit1: not enabled or bad page
      next_st.fail = {!poke_ok, !st.poke_en};
    end
  end

  // state register; watchdog clears like power-up
  always_ff @(posedge sys_clk) begin
    if (!resetn || wd_clear) begin
      next_st_reset_hold: begin
        st <= '0;
      end
    end else begin
      st <= next_st;
    end
  end

  AST_FAIL_DISABLED: assert property (@(posedge sys_clk) disable iff (!resetn)
    (poke_try && !st.poke_en && !wd_clear) |=> (fail == 2'b11))
    else $error("poke while disabled did not flag failure");
  AST_EN_PERSIST: assert property (@(posedge sys_clk) disable iff (!resetn)
    (poke_en && !en_clr && !wd_clear) |=> poke_en)
    else $error("poke enable lost without disable or reset");
  AST_BAD_PAGE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (poke_try && st.page > MAX_PAGE && !wd_clear) |=> fail[1] && !$past(poke_ok))
    else $error("poke with illegal page not rejected");
  AST_LEN_FIRST: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cmd_wr && cmd_pointer == ENERGY_PTR && !wd_clear) |=> (readout_word == ENERGY_LEN))
    else $error("energy readout does not start with length word");
  AST_LSW_NEXT: assert property (@(posedge sys_clk) disable iff (!resetn)
    (data_rd && !cmd_wr && !wd_clear && pointer == ENERGY_PTR && st.idx == 3'h0)
    |=> (readout_word == st.snap_e[15:0]))
    else $error("energy word order wrong");
  AST_PAST_END: assert property (@(posedge sys_clk) disable iff (!resetn)
    (data_rd && !cmd_wr && !wd_clear && pointer == ENERGY_PTR && st.idx >= 3'h6)
    |=> (readout_word == 16'h0000))
    else $error("read past end of readout not zero");
endmodule
`default_nettype wire

/* logic/indirect_peek_poke_port.sv */
`timescale 1ns/100ps
`default_nettype none
module indirect_peek_poke_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // watchdog reset pin
  input wire logic watchdog_input,
  // energy accumulators, same clock
  input wire logic [47:0] energy_value,
  input wire logic [47:0] energy_time,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic irq
);
  import ipp_pkg::*;

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  top_state_t st;
  top_state_t next_st;
  logic [WORD_W-1:0] mem [0:MEM_DEPTH-1];

  logic req;
  logic wr;
  logic rd;
  logic word_wr;
  logic [15:0] wdat;
  logic cmd_wr_a;
  logic cmd_wr_b;
  logic en_set_a;
  logic en_clr_a;
  logic en_set_b;
  logic en_clr_b;
  logic data_rd_a;
  logic data_rd_b;
  logic poke_try_a;
  logic poke_try_b;
  logic [PTR_W-1:0] pointer_a;
  logic [PTR_W-1:0] pointer_b;
  logic [PAGE_W-1:0] page_a;
  logic [PAGE_W-1:0] page_b;
  logic poke_en_a;
  logic poke_en_b;
  logic [1:0] fail_a;
  logic [1:0] fail_b;
  logic ok_a;
  logic ok_b;
  logic [15:0] ro_a;
  logic [15:0] ro_b;
  logic mem_we;
  logic [10:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [1:0] events;
  logic special;

  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign irq = st.irq;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // one request per ack; ack blocks a retake in the same access
  always_comb begin
    req = wb_cyc_i && wb_stb_i && !st.ack;
    wr = req && wb_we_i;
    rd = req && !wb_we_i;
    // data and command writes need both low byte lanes
    word_wr = wr && (wb_sel_i[1:0] == 2'b11);
    wdat = wb_dat_i[15:0];
    special = (wdat == CODE_EN_A) || (wdat == CODE_DIS_A) ||
              (wdat == CODE_EN_B) || (wdat == CODE_DIS_B);
    en_set_a = word_wr && wb_adr_i == OFF_CMD && wdat == CODE_EN_A;
    en_clr_a = word_wr && wb_adr_i == OFF_CMD && wdat == CODE_DIS_A;
    en_set_b = word_wr && wb_adr_i == OFF_CMD && wdat == CODE_EN_B;
    en_clr_b = word_wr && wb_adr_i == OFF_CMD && wdat == CODE_DIS_B;
    cmd_wr_a = word_wr && wb_adr_i == OFF_CMD && !special && !wdat[HOST_BIT];
    cmd_wr_b = word_wr && wb_adr_i == OFF_CMD && !special && wdat[HOST_BIT];
    data_rd_a = rd && wb_adr_i == OFF_PORT_A;
    data_rd_b = rd && wb_adr_i == OFF_PORT_B;
    poke_try_a = word_wr && wb_adr_i == OFF_PORT_A;
    poke_try_b = word_wr && wb_adr_i == OFF_PORT_B;
  end

  // ----------------------------------------------------------------
  // per-host cached pointer, page, enable and readout
  // ----------------------------------------------------------------
  host_port u_host_a (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .wd_clear(st.wd_sync),
    .cmd_wr(cmd_wr_a),
    .cmd_pointer(wdat[PTR_W-1:0]),
    .cmd_page(wdat[PAGE_LSB+PAGE_W-1:PAGE_LSB]),
    .en_set(en_set_a),
    .en_clr(en_clr_a),
    .data_rd(data_rd_a),
    .poke_try(poke_try_a),
    .energy_value(energy_value),
    .energy_time(energy_time),
    .pointer(pointer_a),
    .page(page_a),
    .poke_en(poke_en_a),
    .fail(fail_a),
    .poke_ok(ok_a),
    .readout_word(ro_a)
  );

  host_port u_host_b (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .wd_clear(st.wd_sync),
    .cmd_wr(cmd_wr_b),
    .cmd_pointer(wdat[PTR_W-1:0]),
    .cmd_page(wdat[PAGE_LSB+PAGE_W-1:PAGE_LSB]),
    .en_set(en_set_b),
    .en_clr(en_clr_b),
    .data_rd(data_rd_b),
    .poke_try(poke_try_b),
    .energy_value(energy_value),
    .energy_time(energy_time),
    .pointer(pointer_b),
    .page(page_b),
    .poke_en(poke_en_b),
    .fail(fail_b),
    .poke_ok(ok_b),
    .readout_word(ro_b)
  );

  // ----------------------------------------------------------------
  // peek path
  // ----------------------------------------------------------------
  // status locations are visible to either host
  function automatic logic [15:0] peek_word(input logic [PTR_W-1:0] ptr,
                                            input logic [PAGE_W-1:0] pg,
                                            input logic [15:0] ro);
    logic [15:0] w;
    w = 16'h0000;
    if (ptr == ENERGY_PTR) begin
      w = ro;
    end else if (ptr == STAT_A_PTR) begin
      w = {14'h0000, fail_a};
    end else if (ptr == STAT_B_PTR) begin
      w = {14'h0000, fail_b};
    end else if (pg <= MAX_PAGE) begin
      w = mem[{pg[1:0], ptr}];
      if (is_byte_loc(ptr)) begin
        w[15:8] = 8'h00;
      end
    end
    return w;
  endfunction

  // ----------------------------------------------------------------
  // poke path
  // ----------------------------------------------------------------
  // only one host can poke per bus cycle, so one write port suffices
  always_comb begin
    mem_we = (poke_try_a && ok_a) || (poke_try_b && ok_b);
    if (poke_try_b) begin
      mem_addr = {page_b[1:0], pointer_b};
    end else begin
      mem_addr = {page_a[1:0], pointer_a};
    end
    mem_wdata = wdat;
    if (is_byte_loc(poke_try_b ? pointer_b : pointer_a)) begin
      mem_wdata[15:8] = 8'h00;
    end
    events = 2'b00;
    events[EV_POKE_OK] = mem_we;
    events[EV_POKE_FAIL] = (poke_try_a && !ok_a) || (poke_try_b && !ok_b);
  end

  // internal locations; no reset, contents are software's
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  // ----------------------------------------------------------------
  // registers, answer and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.wd_meta = watchdog_input;
    next_st.wd_sync = st.wd_meta;
    next_st.ack = req;
    if (word_wr && wb_adr_i == OFF_CMD) begin
      next_st.cmd_last = wdat;
    end
    if (wr && wb_adr_i == OFF_IRQ_EN && wb_sel_i[0]) begin
      next_st.irq_en = wb_dat_i[1:0];
    end
    // a new event beats a clear in the same cycle
    if (wr && wb_adr_i == OFF_IRQ_CLR && wb_sel_i[0]) begin
      next_st.irq_stat = (st.irq_stat & ~wb_dat_i[1:0]) | events;
    end else begin
      next_st.irq_stat = st.irq_stat | events;
    end
    next_st.irq = |(next_st.irq_stat & next_st.irq_en);
    if (rd) begin
      case (wb_adr_i)
        OFF_CMD: next_st.rdata = {16'h0000, st.cmd_last};
        OFF_PORT_A: next_st.rdata = {16'h0000, peek_word(pointer_a, page_a, ro_a)};
        OFF_PORT_B: next_st.rdata = {16'h0000, peek_word(pointer_b, page_b, ro_b)};
        OFF_IRQ_STAT: next_st.rdata = {30'h0000_0000, st.irq_stat};
        OFF_IRQ_EN: next_st.rdata = {30'h0000_0000, st.irq_en};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end else if (req) begin
      next_st.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_ENABLE_A: assert property (@(posedge sys_clk) disable iff (!resetn)
    (en_set_a && !st.wd_sync) |=> poke_en_a)
    else $error("port A enable code ignored");
  AST_ENABLE_B_ONLY: assert property (@(posedge sys_clk) disable iff (!resetn)
    (en_set_b && !poke_en_a && !st.wd_sync) |=> (poke_en_b && !poke_en_a))
    else $error("port B enable code misrouted");
  AST_CODE_NOT_PTR: assert property (@(posedge sys_clk) disable iff (!resetn)
    (word_wr && wb_adr_i == OFF_CMD && special && !st.wd_sync)
    |=> (pointer_a == $past(pointer_a) && pointer_b == $past(pointer_b)))
    else $error("special code changed a pointer");
  AST_BYTE_HIGH_ZERO: assert property (@(posedge sys_clk) disable iff (!resetn)
    (data_rd_a && is_byte_loc(pointer_a) && page_a <= MAX_PAGE) |=> (wb_ack_o && wb_dat_o[15:8] == 8'h00))
    else $error("byte peek upper byte not zero");
  AST_REJECT_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!resetn)
    ((poke_try_a && !ok_a) || (poke_try_b && !ok_b)) |-> !mem_we)
    else $error("rejected poke wrote memory");
  AST_STATUS_PEEK: assert property (@(posedge sys_clk) disable iff (!resetn)
    (data_rd_a && pointer_a == STAT_A_PTR) |=> (wb_dat_o[15:0] == {14'h0000, $past(fail_a)}))
    else $error("status peek does not show fail flags");
  AST_POKE_STORES: assert property (@(posedge sys_clk) disable iff (!resetn)
    (poke_try_a && ok_a) |=> (mem[$past(mem_addr)] == $past(mem_wdata)))
    else $error("accepted poke not stored");
  AST_ACK_PULSE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (req && !wb_we_i) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("read answer not a single cycle ack");
endmodule
`default_nettype wire

/* logic/ipp_pkg.sv */
`default_nettype none
package ipp_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PTR_W = 9;
  localparam int PAGE_W = 5;
  localparam int WORD_W = 16;
  localparam int MEM_DEPTH = 2048;

  // ----------------------------------------------------------------
  // wishbone byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_PORT_A = 8'h04;
  localparam logic [7:0] OFF_PORT_B = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN = 8'h14;

  // ----------------------------------------------------------------
  // command register layout and special codes
  // ----------------------------------------------------------------
  localparam int HOST_BIT = 14;
  localparam int PAGE_LSB = 9;
  localparam logic [15:0] CODE_EN_A = 16'h0bf6;
  localparam logic [15:0] CODE_DIS_A = 16'h01f6;
  localparam logic [15:0] CODE_EN_B = 16'h4bf6;
  localparam logic [15:0] CODE_DIS_B = 16'h41f6;
  localparam logic [PAGE_W-1:0] MAX_PAGE = 5'h03;

  // ----------------------------------------------------------------
  // internal locations with special meaning
  // ----------------------------------------------------------------
  localparam logic [PTR_W-1:0] ENERGY_PTR = 9'h0c0;
  localparam logic [PTR_W-1:0] STAT_A_PTR = 9'h02c;
  localparam logic [PTR_W-1:0] STAT_B_PTR = 9'h02d;
  localparam logic [WORD_W-1:0] ENERGY_LEN = 16'h000c;
  localparam logic [2:0] IDX_END = 3'h7;

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  localparam int EV_POKE_OK = 0;
  localparam int EV_POKE_FAIL = 1;

  // byte-wide internal locations; all others are words
  function automatic logic is_byte_loc(input logic [PTR_W-1:0] p);
    return (p == 9'h001) || (p == 9'h002) || (p == 9'h0d9) || (p == 9'h0da);
  endfunction

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PTR_W-1:0] pointer;
    logic [PAGE_W-1:0] page;
    logic poke_en;
    logic [1:0] fail;
    logic [2:0] idx;
    logic [47:0] snap_e;
    logic [47:0] snap_t;
  } host_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic irq;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [15:0] cmd_last;
    logic wd_meta;
    logic wd_sync;
  } top_state_t;
endpackage
`default_nettype wire

/* sim/pmbus_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pmbus_host_model (
  // clock and bus answer
  input wire logic sys_clk,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // bus request
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [7:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i
);
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
  end

  // one classic cycle, always all lanes: no byte reads of the data ports
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] rdata, output logic ok);
    ok = 1'b0;
    rdata = 32'h0000_0000;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    // hold the request until ack is seen high at a rising edge; only the bench timeout ends a hang
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    ok = 1'b1;
    rdata = wb_dat_o;
    // released lines carry junk, not the old request
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    wb_sel_i <= 4'h0;
    wb_adr_i <= ~adr;
    wb_dat_i <= ~dat;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ipp_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic watchdog_input = 1'b0;
  logic [47:0] energy_value = 48'h0000_0000_0000;
  logic [47:0] energy_time = 48'h0000_0000_0000;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [8:0] ptr;
  logic [4:0] pg;
  logic [15:0] d;

  always #50 sys_clk = ~sys_clk;

  indirect_peek_poke_port dut (.sys_clk(sys_clk), .resetn(resetn),
    .watchdog_input(watchdog_input), .energy_value(energy_value), .energy_time(energy_time),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq(irq));

  pmbus_host_model host (.sys_clk(sys_clk), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i));

  // ----------------------------------------------------------------
  // checking and bus helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      failures++;
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [15:0] v);
    logic [31:0] r;
    logic ok;
    host.xfer(1'b1, adr, {16'h0000, v}, r, ok);
    if (!ok) failures++;
  endtask

  task automatic rd(input logic [7:0] adr, input logic [15:0] exp);
    logic [31:0] r;
    logic ok;
    host.xfer(1'b0, adr, 32'h0000_0000, r, ok);
    if (!ok) failures++;
    check(r, {16'h0000, exp});
  endtask

  function automatic logic [7:0] port(input logic h);
    return h ? OFF_PORT_B : OFF_PORT_A;
  endfunction

  // command word: host select, page, pointer
  task automatic cmd(input logic h, input logic [4:0] p, input logic [8:0] q);
    wr(OFF_CMD, {1'b0, h, p, q});
  endtask

  task automatic poke(input logic h, input logic [4:0] p, input logic [8:0] q,
                      input logic [15:0] v);
    cmd(h, p, q);
    wr(port(h), v);
  endtask

  task automatic peek(input logic h, input logic [4:0] p, input logic [8:0] q,
                      input logic [15:0] exp);
    cmd(h, p, q);
    rd(port(h), exp);
  endtask

  // flags read back through the status location of that host
  task automatic stat(input logic h, input logic [1:0] f);
    peek(h, 5'h00, h ? STAT_B_PTR : STAT_A_PTR, {14'h0000, f});
  endtask

  task automatic chk_irq(input logic exp);
    @(negedge sys_clk);
    check({31'h0000_0000, irq}, {31'h0000_0000, exp});
    @(posedge sys_clk);
  endtask

  function automatic logic [15:0] ewd(int i, logic [47:0] e, logic [47:0] t);
    case (i)
      0: return 16'h000c;
      1: return e[15:0];
      2: return e[31:16];
      3: return e[47:32];
      4: return t[15:0];
      5: return t[31:16];
      6: return t[47:32];
      default: return 16'h0000;
    endcase
  endfunction

  // seven readout words, then one past the end
  task automatic energy(input logic h);
    energy_value <= 48'({$urandom(), $urandom()});
    energy_time <= 48'({$urandom(), $urandom()});
    @(posedge sys_clk);
    cmd(h, 5'h00, ENERGY_PTR);
    for (int i = 0; i < 8; i++) begin
      rd(port(h), ewd(i, energy_value, energy_time));
    end
  endtask

  // runaway guard, long past the expected few hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h111b));
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk_irq(1'b0);
    rd(8'h18, 16'h0000);
    rd(OFF_IRQ_STAT, 16'h0000);
    $display("test reset done");
    energy(1'b0);
    energy(1'b1);
    $display("test energy done");
    wr(OFF_IRQ_EN, 16'h0002);
    ptr = {1'b1, 8'($urandom())};
    poke(1'b0, 5'h01, ptr, 16'($urandom()));
    stat(1'b0, 2'b11);
    stat(1'b1, 2'b00);
    chk_irq(1'b1);
    wr(OFF_CMD, CODE_EN_A);
    for (int i = 0; i < 6; i++) begin
      // keep clear of the fixed port b locations 0x1f0 and 0x1f1
      ptr = {2'b10, 7'($urandom())};
      pg = 5'($urandom_range(3));
      d = 16'($urandom());
      poke(1'b0, pg, ptr, d);
      peek(1'b0, pg, ptr, d);
      stat(1'b0, 2'b00);
    end
    poke(1'b0, 5'h04 + 5'($urandom_range(27)), ptr, 16'h5a5a);
    stat(1'b0, 2'b10);
    peek(1'b0, 5'h05, ptr, 16'h0000);
    poke(1'b0, 5'h00, 9'h001, 16'habcd);
    peek(1'b0, 5'h00, 9'h001, 16'h00cd);
    $display("test poke a done");
    poke(1'b1, pg, ptr, ~d);
    stat(1'b1, 2'b11);
    stat(1'b0, 2'b00);
    wr(OFF_CMD, CODE_EN_B);
    poke(1'b1, 5'h02, 9'h1f0, 16'h1234);
    peek(1'b1, 5'h02, 9'h1f0, 16'h1234);
    stat(1'b1, 2'b00);
    wr(OFF_CMD, CODE_DIS_A);
    poke(1'b0, pg, ptr, ~d);
    peek(1'b0, pg, ptr, d);
    stat(1'b0, 2'b11);
    poke(1'b1, 5'h03, 9'h1f1, 16'h0f0f);
    stat(1'b1, 2'b00);
    wr(OFF_CMD, CODE_DIS_B);
    poke(1'b1, 5'h03, 9'h1f1, 16'hf0f0);
    peek(1'b1, 5'h03, 9'h1f1, 16'h0f0f);
    $display("test port b done");
    wr(OFF_CMD, CODE_EN_A);
    watchdog_input <= 1'b1;
    repeat (3) @(posedge sys_clk);
    watchdog_input <= 1'b0;
    repeat (5) @(posedge sys_clk);
    poke(1'b0, pg, ptr, ~d);
    stat(1'b0, 2'b11);
    $display("test watchdog done");
    rd(OFF_IRQ_STAT, 16'h0003);
    wr(OFF_IRQ_CLR, 16'h0003);
    chk_irq(1'b0);
    rd(OFF_IRQ_STAT, 16'h0000);
    wr(OFF_IRQ_EN, 16'h0001);
    poke(1'b0, pg, ptr, ~d);
    chk_irq(1'b0);
    rd(OFF_IRQ_STAT, 16'h0002);
    $display("test irq done");
    test_done();
  end
endmodule
`default_nettype wire
